// ===== verilog/pcq_top.sv
// Position compare queue: value queue with bias adder and comparator
// Assumes an AXI4-Lite master and position inputs synchronous to clock_in
//
// Notes on behaviour
// R1: A written value becomes the newest entry
// R2: Writes refused while capacity exceeded
// R3: Oldest unremoved entry is presented
// R4: Target is oldest entry plus bias
// R5: Target recomputed only on first push, remove
// R6: Match when position equals target, held until remove
// R7: Comparator disabled means no match
// R8: Fill alarm while count at or above threshold
// R9: Empty flag while nothing is stored
// R10: Capacity flag when no room remains
// R11: Flush discards every entry
// R12: Program should flush at power-up
// R13: Remove drops oldest entry, clears match (here a compare hit in the same cycle wins and sets it)
// R14: Compare against one selectable position source
// R15: Compare once per update tick, only when non-empty
//
// Our own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
module pcq_top
    import pcq_pkg::*;
(
    input  wire logic              clock_in,              // 125 MHz clock
    input  wire logic              rst_b_in,              // Async reset, active low
    input  wire logic [ADDR_W-1:0] s_axi_awaddr_in,       // Write address
    input  wire logic              s_axi_awvalid_in,      // Write address valid
    output logic                   s_axi_awready_out,     // Write address ready
    input  wire logic [31:0]       s_axi_wdata_in,        // Write data
    input  wire logic [3:0]        s_axi_wstrb_in,        // Write byte strobes
    input  wire logic              s_axi_wvalid_in,       // Write data valid
    output logic                   s_axi_wready_out,      // Write data ready
    output logic [1:0]             s_axi_bresp_out,       // Write response
    output logic                   s_axi_bvalid_out,      // Write response valid
    input  wire logic              s_axi_bready_in,       // Write response ready
    input  wire logic [ADDR_W-1:0] s_axi_araddr_in,       // Read address
    input  wire logic              s_axi_arvalid_in,      // Read address valid
    output logic                   s_axi_arready_out,     // Read address ready
    output logic [31:0]            s_axi_rdata_out,       // Read data
    output logic [1:0]             s_axi_rresp_out,       // Read response
    output logic                   s_axi_rvalid_out,      // Read data valid
    input  wire logic              s_axi_rready_in,       // Read data ready
    input  wire logic [DATA_W-1:0] motor_feedback_in,     // Motor feedback position
    input  wire logic [DATA_W-1:0] master_feedback_in,    // Master feedback position
    input  wire logic [DATA_W-1:0] motor_command_in,      // Motor commanded position
    output logic                   match_event_out,       // Position reached target
    output logic                   nothing_stored_out,    // Queue empty
    output logic                   fill_alarm_out,        // Count at threshold
    output logic                   capacity_exceeded_out  // No room left
);
    // Bus handshake state
    logic              awready_q;
    logic              wready_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;
    logic              arready_q;
    logic              rvalid_q;
    logic [1:0]        rresp_q;
    logic [31:0]       rdata_q;
    logic [31:0]       rdata_d;
    logic              rd_ok;
    logic [ADDR_W-1:0] waddr_q;
    logic [31:0]       wdata_q;
    logic [3:0]        wstrb_q;

    // Control and queue state
    logic              comparator_enable_q;
    pcq_src_t          src_q;
    logic [DATA_W-1:0] target_bias_q;
    logic [CNT_W-1:0]  capacity_limit_q;
    logic [CNT_W-1:0]  fill_threshold_q;
    logic [DATA_W-1:0] match_target_q;
    logic              recalc_q;
    logic              match_q;
    logic              match_d;
    logic              empty_q;
    logic              fill_q;
    logic              ovf_q;
    logic [TICK_W-1:0] tick_cnt_q;
    logic              tick_q;
    logic [DATA_W-1:0] oldest_entry_value;
    logic [CNT_W-1:0]  count;

    // Byte-lane merge of a write into a register image
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return res;
    endfunction

    // Write decode, done once address and data are both held
    wire        do_wr;
    wire        hit_ctrl;
    wire        hit_bias;
    wire        hit_lim;
    wire        hit_thr;
    wire        hit_push;
    wire        hit_pop;
    wire        wr_ok;
    wire [31:0] ctrl_img;
    wire [31:0] ctrl_new;
    wire [31:0] lim_new;
    wire [31:0] thr_new;
    wire [31:0] queue_write_value;
    assign do_wr    = !awready_q && !wready_q && !bvalid_q;
    assign hit_ctrl = waddr_q == OFF_CTRL;
    assign hit_bias = waddr_q == OFF_BIAS;
    assign hit_lim  = waddr_q == OFF_LIMIT;
    assign hit_thr  = waddr_q == OFF_THRESH;
    assign hit_push = waddr_q == OFF_PUSH;
    assign hit_pop  = waddr_q == OFF_REMOVE;
    assign wr_ok    = hit_ctrl || hit_bias || hit_lim || hit_thr || hit_push || hit_pop;
    assign ctrl_img = {29'h0, src_q, comparator_enable_q};
    assign ctrl_new = merge(ctrl_img, wdata_q, wstrb_q);
    assign lim_new  = merge({27'h0, capacity_limit_q}, wdata_q, wstrb_q);
    assign thr_new  = merge({27'h0, fill_threshold_q}, wdata_q, wstrb_q);
    assign queue_write_value = merge(32'h0, wdata_q, wstrb_q);

    // Queue operations taken from the register writes
    wire push_w;
    wire push_go;
    wire pop_w;
    wire flush_w;
    wire ovf_d;
    wire recalc_d;
    assign ovf_d    = count >= capacity_limit_q;                       // R10
    assign push_w   = do_wr && hit_push;
    assign push_go  = push_w && !ovf_d;                                // R2
    assign pop_w    = do_wr && hit_pop;
    assign flush_w  = do_wr && hit_ctrl && ctrl_new[CTRL_FLUSH_BIT];   // R11
    assign recalc_d = (push_go && count == '0) || (pop_w && count != '0); // R5

    // Entry storage
    pcq_store u_store (
        .clock_in   (clock_in),
        .rst_b_in   (rst_b_in),
        .push_in    (push_go),               // R1
        .pop_in     (pop_w),                 // R13
        .flush_in   (flush_w),               // R11
        .data_in    (queue_write_value),
        .oldest_out (oldest_entry_value),    // R3
        .count_out  (count)
    );

    // Position source selection and comparison
    wire [DATA_W-1:0] pos_sel;
    wire              hit_cmp;
    assign pos_sel = (src_q == SRC_MASTER_FB) ? master_feedback_in :
                     (src_q == SRC_MOTOR_CMD) ? motor_command_in :
                     motor_feedback_in;                                // R14
    assign hit_cmp = tick_q && comparator_enable_q && count != '0 &&
                     !recalc_q && pos_sel == match_target_q;           // R15

    // Match flag; a hit in the removal cycle wins over the clear
    always_comb begin
        if (!comparator_enable_q) begin
            match_d = 1'b0;                                            // R7
        end else if (hit_cmp) begin
            match_d = 1'b1;                                            // R6
        end else if (pop_w || flush_w) begin
            match_d = 1'b0;                                            // R13
        end else begin
            match_d = match_q;
        end
    end

    // Motion update tick divider
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tick_cnt_q <= '0;
            tick_q     <= 1'b0;
        end else begin
            tick_q     <= tick_cnt_q == UPDATE_LAST;
            tick_cnt_q <= (tick_cnt_q == UPDATE_LAST) ? '0 : tick_cnt_q + 1'b1;
        end
    end

    // Target, match and status flags
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            match_target_q <= '0;
            recalc_q       <= 1'b0;
            match_q        <= 1'b0;
            empty_q        <= 1'b1;
            fill_q         <= 1'b0;
            ovf_q          <= 1'b0;
        end else begin
            recalc_q <= recalc_d;
            if (recalc_q) begin
                match_target_q <= oldest_entry_value + target_bias_q;  // R4
            end
            match_q <= match_d;
            empty_q <= count == '0;                                    // R9
            fill_q  <= count >= fill_threshold_q;                      // R8
            ovf_q   <= ovf_d;                                          // R10
        end
    end

    // Software settings
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            comparator_enable_q <= 1'b0;
            src_q               <= SRC_MOTOR_FB;
            target_bias_q       <= RST_BIAS;
            capacity_limit_q    <= RST_LIMIT;
            fill_threshold_q    <= RST_THRESH;
        end else if (do_wr) begin
            if (hit_ctrl) begin
                comparator_enable_q <= ctrl_new[CTRL_EN_BIT];
                src_q <= (ctrl_new[CTRL_SRC_LSB +: 2] == 2'h3) ? SRC_MOTOR_FB :
                         pcq_src_t'(ctrl_new[CTRL_SRC_LSB +: 2]);
            end
            if (hit_bias) begin
                target_bias_q <= merge(target_bias_q, wdata_q, wstrb_q);
            end
            if (hit_lim) begin
                capacity_limit_q <= (lim_new > 32'(DEPTH)) ? DEPTH_CNT : lim_new[CNT_W-1:0];
            end
            if (hit_thr) begin
                fill_threshold_q <= thr_new[CNT_W-1:0];
            end
        end
    end

    // Write channels: address and data taken in either order
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
            waddr_q   <= '0;
            wdata_q   <= '0;
            wstrb_q   <= '0;
        end else begin
            if (s_axi_awvalid_in && awready_q) begin
                awready_q <= 1'b0;
                waddr_q   <= s_axi_awaddr_in;
            end
            if (s_axi_wvalid_in && wready_q) begin
                wready_q <= 1'b0;
                wdata_q  <= s_axi_wdata_in;
                wstrb_q  <= s_axi_wstrb_in;
            end
            if (do_wr) begin
                bvalid_q <= 1'b1;
                bresp_q  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_q && s_axi_bready_in) begin
                bvalid_q  <= 1'b0;
                awready_q <= 1'b1;
                wready_q  <= 1'b1;
            end
        end
    end

    // Read decode
    always_comb begin
        rd_ok   = 1'b1;
        rdata_d = 32'h0;
        if (s_axi_araddr_in == OFF_CTRL) begin
            rdata_d = ctrl_img;
        end else if (s_axi_araddr_in == OFF_BIAS) begin
            rdata_d = target_bias_q;
        end else if (s_axi_araddr_in == OFF_LIMIT) begin
            rdata_d = {27'h0, capacity_limit_q};
        end else if (s_axi_araddr_in == OFF_THRESH) begin
            rdata_d = {27'h0, fill_threshold_q};
        end else if (s_axi_araddr_in == OFF_PUSH || s_axi_araddr_in == OFF_REMOVE) begin
            rdata_d = 32'h0;
        end else if (s_axi_araddr_in == OFF_STATUS) begin
            rdata_d[ST_EMPTY_BIT] = empty_q;
            rdata_d[ST_FILL_BIT]  = fill_q;
            rdata_d[ST_OVF_BIT]   = ovf_q;
            rdata_d[ST_MATCH_BIT] = match_q;
            rdata_d[ST_CNT_LSB +: CNT_W] = count;
        end else if (s_axi_araddr_in == OFF_OLDEST) begin
            rdata_d = (count == '0) ? 32'h0 : oldest_entry_value;      // R3
        end else if (s_axi_araddr_in == OFF_TARGET) begin
            rdata_d = match_target_q;
        end else begin
            rd_ok = 1'b0;
        end
    end

    // Read channel
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rresp_q   <= RESP_OKAY;
            rdata_q   <= '0;
        end else if (s_axi_arvalid_in && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rdata_q   <= rdata_d;
            rresp_q   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready_in) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
        end
    end

    // Outputs straight from flip-flops
    assign s_axi_awready_out     = awready_q;
    assign s_axi_wready_out      = wready_q;
    assign s_axi_bvalid_out      = bvalid_q;
    assign s_axi_bresp_out       = bresp_q;
    assign s_axi_arready_out     = arready_q;
    assign s_axi_rvalid_out      = rvalid_q;
    assign s_axi_rresp_out       = rresp_q;
    assign s_axi_rdata_out       = rdata_q;
    assign match_event_out       = match_q;
    assign nothing_stored_out    = empty_q;
    assign fill_alarm_out        = fill_q;
    assign capacity_exceeded_out = ovf_q;

    // Checks on the queue behaviour
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!rst_b_in);
    sequence push_into_empty_s;
        push_go && count == '0;
    endsequence
    sequence target_loaded_s;
        recalc_q ##1 match_target_q == $past(oldest_entry_value) + $past(target_bias_q);
    endsequence
    push_store_a: assert property (push_go && !flush_w && count < DEPTH_CNT |=> // R1
        count == $past(count) + 1'b1 && $past(queue_write_value) == u_store.mem_q[$past(u_store.wr_q)])
        else $error("accepted push not stored");
    full_refuse_a: assert property (push_w && ovf_q && !pop_w && !flush_w |=> // R2
        $stable(count)) else $error("push taken while capacity exceeded");
    first_target_a: assert property (push_into_empty_s |=> target_loaded_s) // R5
        else $error("target not loaded after first push");
    target_hold_a: assert property (!recalc_q |=> $stable(match_target_q)) // R5
        else $error("target changed without recompute");
    target_sum_a: assert property (recalc_q |=> // R4
        match_target_q == $past(oldest_entry_value) + $past(target_bias_q))
        else $error("target is not oldest plus bias");
    match_hold_a: assert property (match_q && comparator_enable_q && !pop_w && !flush_w // R6
        |=> match_q) else $error("match dropped without remove");
    remove_clear_a: assert property (pop_w && !hit_cmp |=> !match_q) // R13
        else $error("remove did not clear match");
    cmp_off_a: assert property (!comparator_enable_q |=> !match_event_out) // R7
        else $error("match raised while comparator off");
    tick_only_a: assert property ($rose(match_q) |-> // R15
        $past(tick_q) && $past(count) != '0) else $error("match outside update tick");
    src_sel_a: assert property ($rose(match_q) && $past(src_q) == SRC_MASTER_FB |-> // R14
        $past(master_feedback_in) == $past(match_target_q)) else $error("wrong position source");
    fill_level_a: assert property (##1 fill_alarm_out == // R8
        ($past(count) >= $past(fill_threshold_q))) else $error("fill alarm wrong");
    empty_flag_a: assert property (##1 nothing_stored_out == ($past(count) == '0)) // R9
        else $error("empty flag wrong");
    cap_flag_a: assert property (##1 capacity_exceeded_out == // R10
        ($past(count) >= $past(capacity_limit_q))) else $error("capacity flag wrong");
    flush_empty_a: assert property (flush_w |=> count == '0 ##1 nothing_stored_out) // R11
        else $error("flush did not empty queue");
endmodule
`default_nettype wire

// ===== verilog/pcq_pkg.sv
// Constants, register map and types for the position compare queue
// Assumes one 125 MHz clock domain and a 32-bit AXI4-Lite register bus
package pcq_pkg;
    // Widths and depth
    localparam int DATA_W = 32;
    localparam int DEPTH  = 16;
    localparam int PTR_W  = 4;
    localparam int CNT_W  = 5;
    localparam int ADDR_W = 8;
    localparam logic [CNT_W-1:0] DEPTH_CNT = 5'h10;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_CTRL   = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_BIAS   = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_LIMIT  = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_THRESH = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_PUSH   = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_REMOVE = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_OLDEST = 8'h1c;
    localparam logic [ADDR_W-1:0] OFF_TARGET = 8'h20;

    // Control register fields
    localparam int CTRL_EN_BIT    = 0;
    localparam int CTRL_SRC_LSB   = 1;
    localparam int CTRL_FLUSH_BIT = 4;

    // Status register fields
    localparam int ST_EMPTY_BIT = 0;
    localparam int ST_FILL_BIT  = 1;
    localparam int ST_OVF_BIT   = 2;
    localparam int ST_MATCH_BIT = 3;
    localparam int ST_CNT_LSB   = 8;

    // Reset values
    localparam logic [CNT_W-1:0]  RST_LIMIT  = 5'h10;
    localparam logic [CNT_W-1:0]  RST_THRESH = 5'h0c;
    localparam logic [DATA_W-1:0] RST_BIAS   = 32'h0;

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Motion update timing
    localparam int CLK_NS     = 8;
    localparam int UPDATE_NS  = 256;
    localparam int UPDATE_CYC = UPDATE_NS / CLK_NS;
    localparam int TICK_W     = 6;
    localparam logic [TICK_W-1:0] UPDATE_LAST = TICK_W'(UPDATE_CYC - 1);

    // Position source selection
    typedef enum logic [1:0] {
        SRC_MOTOR_FB,
        SRC_MASTER_FB,
        SRC_MOTOR_CMD
    } pcq_src_t;
endpackage

// ===== verilog/pcq_store.sv
// Flip-flop ring store holding the queued position values
// Assumes the caller refuses pushes once its own limit is reached
`timescale 1ns/1ns
`default_nettype none
module pcq_store
    import pcq_pkg::*;
(
    input  wire logic              clock_in,   // System clock
    input  wire logic              rst_b_in,   // Async reset, active low
    input  wire logic              push_in,    // Store a new newest entry
    input  wire logic              pop_in,     // Drop the oldest entry
    input  wire logic              flush_in,   // Discard every entry
    input  wire logic [DATA_W-1:0] data_in,    // Value to store
    output logic      [DATA_W-1:0] oldest_out, // Oldest entry held
    output logic      [CNT_W-1:0]  count_out   // Entries held
);
    logic [DATA_W-1:0] mem_q [DEPTH];
    logic [PTR_W-1:0]  wr_q;
    logic [PTR_W-1:0]  rd_q;
    logic [CNT_W-1:0]  cnt_q;
    wire               do_push;
    wire               do_pop;

    // Guard against physical overrun and underrun
    assign do_push    = push_in && (cnt_q < DEPTH_CNT);
    assign do_pop     = pop_in && (cnt_q != '0);
    assign oldest_out = mem_q[rd_q];
    assign count_out  = cnt_q;

    // Entry storage; cleared at reset so a drained queue never reads unknown
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
        end else if (do_push && !flush_in) begin
            mem_q[wr_q] <= data_in;
        end
    end

    // Pointers wrap naturally at the power-of-two depth
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else if (flush_in) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (do_push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (do_pop) begin
                rd_q <= rd_q + 1'b1;
            end
            if (do_push && !do_pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (do_pop && !do_push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ===== bench/pcq_pos_model.sv
// Position source model: drives the three axis position inputs
// Assumes the bench picks which source carries the wanted position
`timescale 1ns/1ns
`default_nettype none
module pcq_pos_model
    import pcq_pkg::*;
(
    input  wire logic              clock_in, // System clock
    input  wire logic [DATA_W-1:0] pos_in,   // Wanted position
    input  wire logic [1:0]        sel_in,   // Source carrying it
    output logic      [DATA_W-1:0] mfb_out,  // Motor feedback
    output logic      [DATA_W-1:0] xfb_out,  // Master feedback
    output logic      [DATA_W-1:0] cmd_out   // Motor command
);
    // Unselected sources carry the inverse so they never match
    always_ff @(posedge clock_in) begin
        mfb_out <= (sel_in == 2'h0) ? pos_in : ~pos_in;
        xfb_out <= (sel_in == 2'h1) ? pos_in : ~pos_in;
        cmd_out <= (sel_in == 2'h2) ? pos_in : ~pos_in;
    end
endmodule
`default_nettype wire

// ===== bench/pcq_top_tb.sv
// Bench for the position compare queue, driven over AXI4-Lite
// Assumes the position model feeds the three position inputs
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin miscompares++; \
    $display("[FAIL] %0t mismatch %h vs %h", $time, a, b); end end
module pcq_top_tb;
    import pcq_pkg::*;
    logic        clock_in = 0, rst_b_in = 0;
    logic [7:0]  awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, pos = 0, mfb, xfb, cmd, rdata;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        awready, wready, bvalid, arready, rvalid, match, empty, fill, cap;
    logic [1:0]  bresp, rresp, sel = 0, r;
    logic [31:0] d;
    int          miscompares = 0, comparisons = 0;
    pcq_top pcq_top_i (.clock_in(clock_in), .rst_b_in(rst_b_in),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
        .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
        .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
        .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
        .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .motor_feedback_in(mfb),
        .master_feedback_in(xfb), .motor_command_in(cmd), .match_event_out(match),
        .nothing_stored_out(empty), .fill_alarm_out(fill), .capacity_exceeded_out(cap));
    pcq_pos_model pcq_pos_model_i (.clock_in(clock_in), .pos_in(pos), .sel_in(sel),
        .mfb_out(mfb), .xfb_out(xfb), .cmd_out(cmd));
    // Clock at 8 ns
    initial forever #4 clock_in = ~clock_in;
    // Verdict and end of run
    task automatic report_and_stop();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Write one word; waits for the response, then one settling edge
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        int  n;
        logic ad, wd, bd;
        ad = 0; wd = 0; bd = 0; n = 0;
        @(posedge clock_in);
        awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
        while (!bd) begin
            @(posedge clock_in);
            n++;
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
            if (bvalid) begin bd = 1; r = bresp; bready <= 0; end
            if (n > 50) begin miscompares++; report_and_stop(); end
        end
        @(posedge clock_in);
    endtask
    // Read one word into d and r
    task automatic rd(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge clock_in);
        araddr <= a; arvalid <= 1; rready <= 1;
        do begin
            @(posedge clock_in);
            n++;
            if (arvalid && arready) arvalid <= 0;
            if (n > 50) begin miscompares++; report_and_stop(); end
        end while (!rvalid);
        d = rdata; r = rresp; rready <= 0;
    endtask
    // Wait up to lim edges for the match flag
    task automatic wait_match(input int lim);
        for (int i = 0; i < lim && match !== 1'b1; i++) @(posedge clock_in);
    endtask
    // Reset values, unmapped access, power-up flush
    task automatic t_reset();
        rd(OFF_LIMIT); `CHK(d, 32'(RST_LIMIT))
        rd(OFF_THRESH); `CHK(d, 32'(RST_THRESH))
        rd(OFF_STATUS); `CHK(d[ST_EMPTY_BIT], 1'b1)
        rd(8'h40); `CHK(r, RESP_SLVERR)
        wr(8'h40, 32'h0); `CHK(r, RESP_SLVERR)
        wr(OFF_CTRL, 32'h10); `CHK(r, RESP_OKAY)
        $display("test reset done");
    endtask
    // Ordering, bias sum and target hold
    task automatic t_order();
        wr(OFF_BIAS, 32'ha);
        for (int i = 0; i < 4; i++) wr(OFF_PUSH, 32'h5 + 2 * i);
        rd(OFF_OLDEST); `CHK(d, 32'h5)
        rd(OFF_TARGET); `CHK(d, 32'hf)
        wr(OFF_BIAS, 32'h64);
        rd(OFF_TARGET); `CHK(d, 32'hf)
        wr(OFF_REMOVE, 32'h0);
        rd(OFF_OLDEST); `CHK(d, 32'h7)
        rd(OFF_TARGET); `CHK(d, 32'h6b)
        $display("test order done");
    endtask
    // Disabled comparator, then a match on each source
    task automatic t_match();
        pos <= 32'h6b;
        repeat (70) @(posedge clock_in);
        `CHK(match, 1'b0)
        for (int s = 0; s < 3; s++) begin
            pos <= 32'h6b + 2 * s; sel <= 2'(s);
            wr(OFF_CTRL, 32'h1 | (s << CTRL_SRC_LSB));
            wait_match(100); `CHK(match, 1'b1)
            pos <= 32'h6c + 2 * s;
            repeat (40) @(posedge clock_in);
            `CHK(match, 1'b1)
            wr(OFF_REMOVE, 32'h0); `CHK(match, 1'b0)
        end
        $display("test match done");
    endtask
    // Threshold, capacity refusal and flush
    task automatic t_fill();
        wr(OFF_CTRL, 32'h10);
        wr(OFF_LIMIT, 32'h4);
        wr(OFF_THRESH, 32'h2);
        for (int i = 1; i < 6; i++) begin
            wr(OFF_PUSH, i);
            `CHK(fill, 1'(i >= 2))
            `CHK(cap, 1'(i >= 4))
        end
        rd(OFF_STATUS); `CHK(d[ST_CNT_LSB +: CNT_W], 5'h4)
        wr(OFF_REMOVE, 32'h0); `CHK(cap, 1'b0)
        `CHK(fill, 1'b1)
        rd(OFF_OLDEST); `CHK(d, 32'h2)
        wr(OFF_CTRL, 32'h10); `CHK(empty, 1'b1)
        rd(OFF_OLDEST); `CHK(d, 32'h0)
        $display("test fill done");
    endtask
    // Main sequence
    initial begin
        repeat (5) @(posedge clock_in);
        rst_b_in <= 1;
        t_reset();
        t_order();
        t_match();
        t_fill();
        report_and_stop();
    end
endmodule
`default_nettype wire
